/* File: src/servo_stop_torque_limit.sv */
// motor stop sequencing, torque clamp and running/limit contact output
// What this block does
// [R1] overtravel bit clear: stop as on servo off, brake or coast per bit 6
// [R2] overtravel bit set: decelerate with the emergency stop torque
// [R3] after deceleration stop: servo off if bit 9 clear, else zero clamp
// [R4] in torque control mode overtravel always stops as on servo off
// [R5] emergency torque in percent, 0 to maximum, only with overtravel in use
// [R6] servo-on off, alarm or power loss enter servo off and stop
// [R7] servo off stop: dynamic brake when bit 6 clear, coast when set
// [R8] after brake stop: release if bit 7 clear, keep brake if set
// [R9] forward and reverse torque clamped to own percent limits
// [R10] select bit set: output closed while torque reference exceeds limit
// [R11] external limits count only while their contact input is active
// [R12] select bit clear: output closed while speed at or above level
// [R13] output change mirrored in monitor word bit 4 and status
// [R14] overtravel input high prohibits rotation in that direction
// [R15] overtravel-use bit set ignores that input, rotation allowed
// [R16] motor counts as stopped below a small zero-speed threshold
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module servo_stop_torque_limit (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [stop_torque_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [stop_torque_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [stop_torque_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [stop_torque_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic servo_on_n_i,
   input wire logic forward_overtravel_input_i,
   input wire logic reverse_overtravel_input_i,
   input wire logic fwd_ext_limit_input_n_i,
   input wire logic rev_ext_limit_input_n_i,
   input wire logic alarm_i,
   input wire logic power_ok_i,
   input wire logic torque_mode_i,
   input wire logic signed [15:0] speed_i,
   input wire logic signed [15:0] torque_ref_i,
   output logic signed [15:0] torque_cmd_o,
   output logic motor_power_o,
   output logic dyn_brake_o,
   output logic decel_active_o,
   output logic zero_clamp_o,
   output logic fwd_allow_o,
   output logic rev_allow_o,
   output logic running_or_limit_output_n_o,
   output logic irq_o
);
   import stop_torque_pkg::*;

   logic [4:0] pin_lvl;
   logic servo_on_s, fwd_ot_s, rev_ot_s, fwd_ext_s, rev_ext_s;
   logic [15:0] stop_and_output_switches_reg;
   logic [15:0] emergency_stop_torque_reg;
   logic [15:0] forward_torque_limit_reg, reverse_torque_limit_reg;
   logic [15:0] forward_external_limit_reg, reverse_external_limit_reg;
   logic [15:0] running_level_param_reg;
   logic [EV_W-1:0] status_reg, mask_reg, events;
   logic [15:0] monitor_status_word;
   logic aw_hold_reg, w_hold_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write, wr_mapped, rd_mapped;
   logic [DATA_W-1:0] rd_word;
   stop_state_t state_reg, state_next, soff_state;
   logic soff_cond, fwd_blocked, rev_blocked, ot_hit, stopped;
   logic [15:0] speed_mag, ref_mag, fwd_eff, rev_eff, estop_val;
   logic lim_exceed, running, out_n_next;
   logic signed [15:0] torque_cmd_next;

   // byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
      input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge16

   function automatic logic [15:0] umin(input logic [15:0] a,
      input logic [15:0] b);
      umin = (a < b) ? a : b;
   endfunction : umin

   // contact pins pass the three-stage synchroniser
   pin_sync #(.W(5)) u_sync (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i({!servo_on_n_i, forward_overtravel_input_i,
              reverse_overtravel_input_i, !fwd_ext_limit_input_n_i,
              !rev_ext_limit_input_n_i}),
      .level_o(pin_lvl)
   );
   // inverted first: reset reads servo off, limits off
   assign servo_on_s = pin_lvl[4];
   assign fwd_ot_s = pin_lvl[3];
   assign rev_ot_s = pin_lvl[2];
   assign fwd_ext_s = pin_lvl[1]; // contact closed pulls the pin low
   assign rev_ext_s = pin_lvl[0];

   // axi write channels, address and data taken in either order
   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
   assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         waddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_mapped ? RESP_OK : RESP_SLVERR;
         end
         else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // address decode shared by both directions
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a[1:0] == 2'h0) && (a <= MONITOR_OFS);
   endfunction : mapped
   assign wr_mapped = mapped(waddr_reg) && (waddr_reg != MONITOR_OFS);
   assign rd_mapped = mapped(s_axi_araddr);

   // settings registers written by software
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stop_and_output_switches_reg <= SWITCHES_RST;
         emergency_stop_torque_reg <= MAX_TORQUE; // [R5]
         forward_torque_limit_reg <= MAX_TORQUE; // [R9]
         reverse_torque_limit_reg <= MAX_TORQUE;
         forward_external_limit_reg <= EXT_LIM_RST;
         reverse_external_limit_reg <= EXT_LIM_RST;
         running_level_param_reg <= RUN_LVL_RST;
         mask_reg <= 3'h0;
      end
      else if (do_write)
      begin
         case (waddr_reg)
            SWITCHES_OFS: stop_and_output_switches_reg <=
               merge16(stop_and_output_switches_reg, wdata_reg, wstrb_reg);
            ESTOP_OFS: emergency_stop_torque_reg <=
               merge16(emergency_stop_torque_reg, wdata_reg, wstrb_reg);
            FWD_LIM_OFS: forward_torque_limit_reg <=
               merge16(forward_torque_limit_reg, wdata_reg, wstrb_reg);
            REV_LIM_OFS: reverse_torque_limit_reg <=
               merge16(reverse_torque_limit_reg, wdata_reg, wstrb_reg);
            FWD_EXT_OFS: forward_external_limit_reg <=
               merge16(forward_external_limit_reg, wdata_reg, wstrb_reg);
            REV_EXT_OFS: reverse_external_limit_reg <=
               merge16(reverse_external_limit_reg, wdata_reg, wstrb_reg);
            RUN_LVL_OFS: running_level_param_reg <=
               merge16(running_level_param_reg, wdata_reg, wstrb_reg);
            MASK_OFS:
               if (wstrb_reg[0])
                  mask_reg <= wdata_reg[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // sticky events, write one to clear, a new event wins over the clear
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         status_reg <= 3'h0;
      else if (do_write && waddr_reg == STATUS_OFS && wstrb_reg[0])
         status_reg <= (status_reg & ~wdata_reg[EV_W-1:0]) | events;
      else
         status_reg <= status_reg | events;
   end
   assign irq_o = |(status_reg & mask_reg);

   // read data mux
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         SWITCHES_OFS: rd_word[15:0] = stop_and_output_switches_reg;
         ESTOP_OFS: rd_word[15:0] = emergency_stop_torque_reg;
         FWD_LIM_OFS: rd_word[15:0] = forward_torque_limit_reg;
         REV_LIM_OFS: rd_word[15:0] = reverse_torque_limit_reg;
         FWD_EXT_OFS: rd_word[15:0] = forward_external_limit_reg;
         REV_EXT_OFS: rd_word[15:0] = reverse_external_limit_reg;
         RUN_LVL_OFS: rd_word[15:0] = running_level_param_reg;
         STATUS_OFS: rd_word[EV_W-1:0] = status_reg;
         MASK_OFS: rd_word[EV_W-1:0] = mask_reg;
         MONITOR_OFS: rd_word[15:0] = monitor_status_word;
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // axi read channel, answer one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OK;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_mapped ? RESP_OK : RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // stop conditions and magnitudes
   assign speed_mag = speed_i[15] ? 16'(-speed_i) : 16'(speed_i);
   assign ref_mag = torque_ref_i[15] ? 16'(-torque_ref_i) : 16'(torque_ref_i);
   assign stopped = speed_mag < ZERO_SPEED; // [R16]
   assign soff_cond = !servo_on_s || alarm_i || !power_ok_i; // [R6]
   assign soff_state = stop_and_output_switches_reg[COAST_BIT] ?
      ST_COAST : ST_DB; // [R7]
   assign fwd_blocked = fwd_ot_s &&
      !stop_and_output_switches_reg[FWD_OT_OFF_BIT]; // [R14] [R15]
   assign rev_blocked = rev_ot_s &&
      !stop_and_output_switches_reg[REV_OT_OFF_BIT]; // [R14] [R15]
   assign ot_hit = (fwd_blocked && !speed_i[15] && !stopped) ||
      (rev_blocked && speed_i[15] && !stopped);
   assign estop_val = umin(emergency_stop_torque_reg, MAX_TORQUE); // [R5]

   // stop sequencer
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_RUN:
            if (soff_cond)
               state_next = soff_state; // [R6]
            else if (ot_hit)
               state_next = (stop_and_output_switches_reg[DECEL_BIT] &&
                  !torque_mode_i) ? ST_DECEL : soff_state; // [R1] [R2] [R4]
         ST_DB:
            if (stopped)
               state_next = stop_and_output_switches_reg[HOLD_BIT] ?
                  ST_HELD : ST_FREE; // [R8]
         ST_COAST:
            if (stopped)
               state_next = ST_FREE;
         ST_DECEL:
            if (soff_cond)
               state_next = soff_state;
            else if (stopped)
               state_next = stop_and_output_switches_reg[CLAMP_BIT] ?
                  ST_CLAMP : soff_state; // [R3]
         ST_CLAMP:
            if (soff_cond)
               state_next = soff_state;
            else if (!fwd_blocked && !rev_blocked)
               state_next = ST_RUN;
         ST_HELD, ST_FREE:
            if (!soff_cond && !ot_hit)
               state_next = ST_RUN;
         default: state_next = ST_RUN;
      endcase
   end

   // state and power-stage outputs
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_FREE;
         motor_power_o <= 1'b0;
         dyn_brake_o <= 1'b0;
         decel_active_o <= 1'b0;
         zero_clamp_o <= 1'b0;
         fwd_allow_o <= 1'b0;
         rev_allow_o <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         motor_power_o <= state_next == ST_RUN || state_next == ST_DECEL ||
            state_next == ST_CLAMP;
         dyn_brake_o <= state_next == ST_DB || state_next == ST_HELD; // [R8]
         decel_active_o <= state_next == ST_DECEL;
         zero_clamp_o <= state_next == ST_CLAMP;
         fwd_allow_o <= !fwd_blocked;
         rev_allow_o <= !rev_blocked;
      end
   end

   // effective limits, external ones only while their contact is on
   assign fwd_eff = umin(umin(forward_torque_limit_reg, MAX_TORQUE),
      fwd_ext_s ? forward_external_limit_reg : MAX_TORQUE); // [R9] [R11]
   assign rev_eff = umin(umin(reverse_torque_limit_reg, MAX_TORQUE),
      rev_ext_s ? reverse_external_limit_reg : MAX_TORQUE); // [R9] [R11]
   assign lim_exceed = torque_ref_i[15] ? (ref_mag > rev_eff) :
      (ref_mag > fwd_eff);
   assign running = speed_mag >= running_level_param_reg;
   assign out_n_next = stop_and_output_switches_reg[OUT_SEL_BIT] ?
      !lim_exceed : !running; // [R10] [R12]

   // torque command: braking torque, clamp, direction prohibit
   always_comb
   begin
      torque_cmd_next = 16'sh0000;
      if (state_next == ST_DECEL)
         torque_cmd_next = speed_i[15] ? signed'(estop_val) :
            16'(-signed'(estop_val)); // [R2]
      else if (state_next == ST_RUN && !torque_ref_i[15] && !fwd_blocked)
         torque_cmd_next = signed'(umin(ref_mag, fwd_eff)); // [R9]
      else if (state_next == ST_RUN && torque_ref_i[15] && !rev_blocked)
         torque_cmd_next = 16'(-signed'(umin(ref_mag, rev_eff))); // [R9]
   end

   // contact output and torque command registers
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         running_or_limit_output_n_o <= 1'b1;
         torque_cmd_o <= 16'sh0000;
      end
      else
      begin
         running_or_limit_output_n_o <= out_n_next;
         torque_cmd_o <= torque_cmd_next;
      end
   end

   // events and monitor word follow the output and the sequencer
   assign events[EV_OUT] = out_n_next != running_or_limit_output_n_o; // [R13]
   assign events[EV_OT] = state_reg == ST_RUN && !soff_cond && ot_hit;
   assign events[EV_SOFF] = state_reg != ST_DB && state_reg != ST_COAST &&
      state_reg != ST_HELD && state_reg != ST_FREE && soff_cond;
   always_comb
   begin
      monitor_status_word = 16'h0000;
      monitor_status_word[MON_OUT_BIT] = !running_or_limit_output_n_o; // [R13]
      monitor_status_word[MON_FWD_OK_BIT] = fwd_allow_o;
      monitor_status_word[MON_REV_OK_BIT] = rev_allow_o;
      monitor_status_word[MON_STATE_LSB +: 3] = state_reg;
   end

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_run_ot;
      state_reg == ST_RUN && !soff_cond && ot_hit;
   endsequence
   sequence s_decel_done;
      state_reg == ST_DECEL && !soff_cond && stopped;
   endsequence

   property p_ot_as_soff;
      s_run_ot ##0 (!stop_and_output_switches_reg[DECEL_BIT] &&
         !stop_and_output_switches_reg[COAST_BIT])
      |=> state_reg == ST_DB && dyn_brake_o && !motor_power_o;
   endproperty
   a_ot_as_soff: assert property (p_ot_as_soff) // [R1]
      else $error("overtravel did not brake as on servo off");

   property p_ot_decel;
      s_run_ot ##0 (stop_and_output_switches_reg[DECEL_BIT] && !torque_mode_i)
      |=> decel_active_o && motor_power_o &&
         (torque_cmd_o == signed'(estop_val) ||
          torque_cmd_o == 16'(-signed'(estop_val)));
   endproperty
   a_ot_decel: assert property (p_ot_decel) // [R2]
      else $error("overtravel deceleration not started with stop torque");

   property p_post_clamp;
      s_decel_done ##0 stop_and_output_switches_reg[CLAMP_BIT]
      |=> zero_clamp_o && state_reg == ST_CLAMP;
   endproperty
   a_post_clamp: assert property (p_post_clamp) // [R3]
      else $error("no zero clamp after deceleration stop");

   property p_torque_mode;
      s_run_ot ##0 torque_mode_i |=> !decel_active_o && !motor_power_o;
   endproperty
   a_torque_mode: assert property (p_torque_mode) // [R4]
      else $error("torque mode overtravel decelerated");

   property p_soff;
      state_reg == ST_RUN && soff_cond |=> !motor_power_o ##1
         (state_reg != ST_RUN || !soff_cond);
   endproperty
   a_soff: assert property (p_soff) // [R6]
      else $error("servo off condition did not remove power");

   property p_coast;
      state_reg == ST_COAST |-> !dyn_brake_o && !motor_power_o;
   endproperty
   a_coast: assert property (p_coast) // [R7]
      else $error("coast stop with brake or power on");

   property p_hold;
      state_reg == ST_DB && stopped && stop_and_output_switches_reg[HOLD_BIT]
      |=> dyn_brake_o [*2];
   endproperty
   a_hold: assert property (p_hold) // [R8]
      else $error("brake released although hold selected");

   property p_limit_out;
      stop_and_output_switches_reg[OUT_SEL_BIT] && lim_exceed
      |=> !running_or_limit_output_n_o;
   endproperty
   a_limit_out: assert property (p_limit_out) // [R10]
      else $error("limit output not closed while torque exceeded");

   property p_run_out;
      !stop_and_output_switches_reg[OUT_SEL_BIT]
      |=> running_or_limit_output_n_o == !$past(running);
   endproperty
   a_run_out: assert property (p_run_out) // [R12]
      else $error("running output disagrees with speed");

   property p_mirror;
      $changed(running_or_limit_output_n_o) |->
         status_reg[EV_OUT] && monitor_status_word[MON_OUT_BIT] ==
         !running_or_limit_output_n_o;
   endproperty
   a_mirror: assert property (p_mirror) // [R13]
      else $error("output change not mirrored");

   property p_prohibit;
      !fwd_allow_o |-> torque_cmd_o <= 16'sh0000 || decel_active_o;
   endproperty
   a_prohibit: assert property (p_prohibit) // [R14]
      else $error("forward torque while forward prohibited");
endmodule : servo_stop_torque_limit

/* File: src/stop_torque_pkg.sv */
// constants, register map and state type for the stop and torque-limit block
package stop_torque_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte offsets
   localparam logic [7:0] SWITCHES_OFS = 8'h00;
   localparam logic [7:0] ESTOP_OFS = 8'h04;
   localparam logic [7:0] FWD_LIM_OFS = 8'h08;
   localparam logic [7:0] REV_LIM_OFS = 8'h0C;
   localparam logic [7:0] FWD_EXT_OFS = 8'h10;
   localparam logic [7:0] REV_EXT_OFS = 8'h14;
   localparam logic [7:0] RUN_LVL_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1C;
   localparam logic [7:0] MASK_OFS = 8'h20;
   localparam logic [7:0] MONITOR_OFS = 8'h24;
   // switch register fields
   localparam int FWD_OT_OFF_BIT = 2;
   localparam int REV_OT_OFF_BIT = 3;
   localparam int OUT_SEL_BIT = 4;
   localparam int COAST_BIT = 6;
   localparam int HOLD_BIT = 7;
   localparam int DECEL_BIT = 8;
   localparam int CLAMP_BIT = 9;
   // monitor word fields
   localparam int MON_OUT_BIT = 4;
   localparam int MON_FWD_OK_BIT = 0;
   localparam int MON_REV_OK_BIT = 1;
   localparam int MON_STATE_LSB = 8;
   // event bits in status and mask
   localparam int EV_OUT = 0;
   localparam int EV_OT = 1;
   localparam int EV_SOFF = 2;
   localparam int EV_W = 3;
   // reset values, torques in percent of rated torque
   localparam logic [15:0] MAX_TORQUE = 16'h012C;
   localparam logic [15:0] SWITCHES_RST = 16'h0080;
   localparam logic [15:0] EXT_LIM_RST = 16'h0064;
   localparam logic [15:0] RUN_LVL_RST = 16'h0014;
   localparam logic [15:0] ZERO_SPEED = 16'h0004;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_RUN, ST_DB, ST_COAST, ST_DECEL, ST_CLAMP, ST_HELD, ST_FREE
   } stop_state_t;
endpackage : stop_torque_pkg

/* File: src/pin_sync.sv */
// three-stage pin synchroniser, output follows once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 5
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);
   // one chain per pin
   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge ref_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               level_o[g] <= 1'b0;
            end
            else
            begin
               s1_reg <= pin_i[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
                  level_o[g] <= s3_reg;
            end
         end
      end
   endgenerate
endmodule : pin_sync

/* File: tb/host_contacts.sv */
// host controller model driving the servo contact inputs
`timescale 1ns/1ps
module host_contacts (
   input wire logic ref_clk_i,
   output logic servo_on_n_o,
   output logic fwd_ot_o,
   output logic rev_ot_o,
   output logic fwd_cl_n_o,
   output logic rev_cl_n_o
);
   // idle: servo on request, no overtravel, external limits off
   initial {servo_on_n_o, fwd_ot_o, rev_ot_o, fwd_cl_n_o, rev_cl_n_o} = 5'h03;
   // contacts change just after a rising edge and then hold
   task set_pins(input logic [4:0] p);
      @(posedge ref_clk_i);
      {servo_on_n_o, fwd_ot_o, rev_ot_o, fwd_cl_n_o, rev_cl_n_o} <= p;
   endtask : set_pins
endmodule : host_contacts

/* File: tb/tb_servo_stop_torque_limit.sv */
// self-checking bench for the stop and torque-limit block
`timescale 1ns/1ps
module tb_servo_stop_torque_limit;
   import stop_torque_pkg::*;
   logic ref_clk_i, rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, alarm_i, power_ok_i;
   logic servo_on_n_i, forward_overtravel_input_i, reverse_overtravel_input_i;
   logic fwd_ext_limit_input_n_i, rev_ext_limit_input_n_i, torque_mode_i;
   logic motor_power_o, dyn_brake_o, decel_active_o, zero_clamp_o, irq_o;
   logic fwd_allow_o, rev_allow_o, running_or_limit_output_n_o;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
   logic signed [15:0] speed_i, torque_ref_i, torque_cmd_o;
   int failures = 0;
   int comparisons = 0;
   servo_stop_torque_limit i_dut (.ref_clk_i, .rst_n_i, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .servo_on_n_i, .forward_overtravel_input_i, .reverse_overtravel_input_i,
      .fwd_ext_limit_input_n_i, .rev_ext_limit_input_n_i, .alarm_i,
      .power_ok_i, .torque_mode_i, .speed_i, .torque_ref_i, .torque_cmd_o,
      .motor_power_o, .dyn_brake_o, .decel_active_o, .zero_clamp_o,
      .fwd_allow_o, .rev_allow_o, .running_or_limit_output_n_o, .irq_o);
   host_contacts host (.ref_clk_i, .servo_on_n_o(servo_on_n_i),
      .fwd_ot_o(forward_overtravel_input_i),
      .rev_ot_o(reverse_overtravel_input_i),
      .fwd_cl_n_o(fwd_ext_limit_input_n_i),
      .rev_cl_n_o(rev_ext_limit_input_n_i));
   // 10 MHz clock
   initial
   begin
      ref_clk_i = 1'b0;
      forever #50 ref_clk_i = ~ref_clk_i;
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         failures++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task w(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask : w
   // axi-lite write: address and data offered together, each released when taken
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, wd, b;
      @(posedge ref_clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 1'b0;
      while (!b)
      begin
         @(negedge ref_clk_i);
         aw = s_axi_awvalid && s_axi_awready;
         wd = s_axi_wvalid && s_axi_wready;
         b = s_axi_bvalid;
         wr_resp = s_axi_bresp;
         @(posedge ref_clk_i);
         if (aw) s_axi_awvalid <= 1'b0;
         if (wd) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask : wr
   // axi-lite read, data and response taken at the falling edge that sees rvalid
   task rd(input logic [7:0] a);
      logic r, ar;
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 1'b0;
      while (!r)
      begin
         @(negedge ref_clk_i);
         ar = s_axi_arvalid && s_axi_arready;
         r = s_axi_rvalid;
         rd_data = s_axi_rdata;
         rd_resp = s_axi_rresp;
         @(posedge ref_clk_i);
         if (ar) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask : rd
   task t_regs;
      rd(SWITCHES_OFS);
      chk("switches", 32'h0000_0080, rd_data);
      rd(ESTOP_OFS);
      chk("estop", 32'h0000_012C, rd_data);
      rd(REV_LIM_OFS);
      chk("rev_lim", 32'h0000_012C, rd_data);
      rd(8'h28);
      chk("unmapped", RESP_SLVERR, rd_resp);
      wr(MONITOR_OFS, 32'h0000_0000);
      chk("monitor_wr", RESP_SLVERR, wr_resp);
      $display("test regs done");
   endtask : t_regs
   task t_run;
      wr(MASK_OFS, 32'h0000_0001);
      speed_i <= 16'sh0014;
      w(3);
      chk("run_out", 1'b0, running_or_limit_output_n_o);
      chk("irq_set", 1'b1, irq_o);
      rd(MONITOR_OFS);
      chk("mon_bit4", 1'b1, rd_data[MON_OUT_BIT]);
      speed_i <= 16'sh0013;
      w(3);
      chk("run_off", 1'b1, running_or_limit_output_n_o);
      wr(STATUS_OFS, 32'h0000_0001);
      w(2);
      chk("irq_clr", 1'b0, irq_o);
      $display("test running output done");
   endtask : t_run
   task t_lim;
      wr(SWITCHES_OFS, 32'h0000_0090);
      wr(FWD_LIM_OFS, 32'h0000_0064);
      torque_ref_i <= 16'sh0065;
      w(3);
      chk("over", 1'b0, running_or_limit_output_n_o);
      chk("clamp", 32'h0000_0064, torque_cmd_o);
      @(posedge ref_clk_i);
      torque_ref_i <= 16'sh0064;
      w(3);
      chk("equal", 1'b1, running_or_limit_output_n_o);
      wr(FWD_LIM_OFS, 32'h0000_012C);
      host.set_pins(5'h01);
      torque_ref_i <= 16'sh0096;
      w(6);
      chk("ext_on", 1'b0, running_or_limit_output_n_o);
      @(posedge ref_clk_i);
      torque_ref_i <= -16'sh0096;
      w(3);
      chk("rev_no_ext", 1'b1, running_or_limit_output_n_o);
      host.set_pins(5'h03);
      torque_ref_i <= 16'sh0000;
      wr(SWITCHES_OFS, 32'h0000_0380);
      $display("test torque limit done");
   endtask : t_lim
   task t_stop;
      speed_i <= 16'sh0064;
      host.set_pins(5'h0B);
      w(6);
      chk("fwd_allow", 1'b0, fwd_allow_o);
      chk("decel", 1'b1, decel_active_o);
      chk("decel_trq", 32'hFFFF_FED4, torque_cmd_o);
      @(posedge ref_clk_i);
      speed_i <= 16'sh0000;
      w(3);
      chk("zclamp", 1'b1, zero_clamp_o);
      host.set_pins(5'h13);
      speed_i <= 16'sh0064;
      w(6);
      chk("dbrake", 1'b1, dyn_brake_o);
      @(posedge ref_clk_i);
      speed_i <= 16'sh0000;
      w(3);
      rd(MONITOR_OFS);
      chk("held", 3'h5, rd_data[10:8]);
      wr(SWITCHES_OFS, 32'h0000_0040);
      host.set_pins(5'h03);
      w(6);
      host.set_pins(5'h0B);
      speed_i <= 16'sh0064;
      w(6);
      chk("ot_coast", 1'b0, motor_power_o || dyn_brake_o);
      chk("rev_allow", 1'b1, rev_allow_o);
      $display("test stop done");
   endtask : t_stop
   task end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // watchdog over about 20000 cycles
   initial
   begin
      #2_000_000;
      failures++;
      end_sim();
   end
   initial
   begin
      {rst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, alarm_i, torque_mode_i, speed_i, torque_ref_i} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      power_ok_i = 1'b1;
      repeat (20) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
      w(6);
      t_regs();
      t_run();
      t_lim();
      t_stop();
      end_sim();
   end
endmodule : tb_servo_stop_torque_limit
